// ### gpio_low_level_pwm.sv
/*
 PWM generator for general pin one with AHB-Lite register slave.
 Assumes one AHB-Lite master, word accesses, and a pad that takes
 pinOut while pinOe is high.
*/
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "gpio_pwm_defines.svh"

// Notes on behaviour
// - Tick every 16, 64, 256 or 1024 clocks by tick-select code.
// - Waveform runs from the tick only while the pin is an output.
// - The same tick goes out to the pin's PWM encoder.
// - Low drive level gives the low-level waveform, not a constant low.
// - Period is high count plus low count, times the tick interval.
// - High phase lasts high-count ticks, field bits 13 to 7.
// - Low phase lasts low-count ticks, field bits 6 to 0.
// - Zero high count gives a static low.
// - Zero low count with nonzero high count gives a static high.
// - Both counts zero give a static low.
// - Low-level config at index 51h resets to 007Fh, static low.
// - High drive level uses the companion counts, same time base.
module gpio_low_level_pwm
	import gpio_pwm_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        clkEn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	output logic             pinOut,
	output logic             pinOe,
	output logic             encoderTick
);
	logic [15:0] cfgLow;
	logic [15:0] cfgHigh;
	logic [1:0]  ctrl;
	logic        wrPend;
	logic [7:0]  wrIdx;
	logic [15:0] next_cfgLow;
	logic [15:0] next_cfgHigh;
	logic [1:0]  next_ctrl;
	logic        next_wrPend;
	logic [7:0]  next_wrIdx;
	logic [31:0] next_hrdata;
	logic        addrTake;
	logic        mapped;
	logic [9:0]  tickCnt;
	logic [9:0]  next_tickCnt;
	logic [9:0]  divM1;
	logic        tick;
	phase_e      phase;
	phase_e      next_phase;
	logic [6:0]  phaseCnt;
	logic [6:0]  next_phaseCnt;
	count_s      act;
	count_s      next_act;
	count_s      selCnt;
	logic        selWave;
	logic        next_pinOut;
	logic        next_pinOe;

	// Stall only while the clock enable holds the block
	assign hreadyout = clkEn;
	assign hresp     = 1'b0;
	assign addrTake  = hsel && htrans[1] && hready && clkEn;
	assign mapped    = (haddr[31:10] == 22'h000000);

	// Register file and read data
	always_comb
	begin
		next_cfgLow  = cfgLow;
		next_cfgHigh = cfgHigh;
		next_ctrl    = ctrl;
		if (wrPend)
		begin
			unique case (wrIdx)
				`LL_CFG_IDX: next_cfgLow = hwdata[15:0];
				`LH_CFG_IDX: next_cfgHigh = {2'b00, hwdata[13:0]};
				`CTRL_IDX:   next_ctrl = hwdata[1:0];
				default:     next_ctrl = ctrl;
			endcase
		end
		next_wrPend = addrTake && hwrite && mapped;
		next_wrIdx  = haddr[9:2];
		next_hrdata = 32'h00000000;
		if (addrTake && !hwrite && mapped)
		begin
			unique case (haddr[9:2])
				`LL_CFG_IDX: next_hrdata = {16'h0000, next_cfgLow};
				`LH_CFG_IDX: next_hrdata = {16'h0000, next_cfgHigh};
				`CTRL_IDX:
					next_hrdata = {23'h000000, pinOut, 2'b00,
						phase, 2'b00, next_ctrl};
				default:     next_hrdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			cfgLow  <= `LL_CFG_RST;
			cfgHigh <= `LH_CFG_RST;
			ctrl    <= `CTRL_RST;
			wrPend  <= 1'b0;
			wrIdx   <= 8'h00;
			hrdata  <= 32'h00000000;
		end
		else if (clkEn)
		begin
			cfgLow  <= next_cfgLow;
			cfgHigh <= next_cfgHigh;
			ctrl    <= next_ctrl;
			wrPend  <= next_wrPend;
			wrIdx   <= next_wrIdx;
			hrdata  <= next_hrdata;
		end
	end

	// Time base
	always_comb
	begin
		unique case (cfgLow[`TB_MSB:`TB_LSB])
			2'b00: divM1 = `TB_DIV16_M1;
			2'b01: divM1 = `TB_DIV64_M1;
			2'b10: divM1 = `TB_DIV256_M1;
			2'b11: divM1 = `TB_DIV1K_M1;
		endcase
	end

	// Compare with >= so a shorter base never runs to wrap
	assign tick = (tickCnt >= divM1);
	assign next_tickCnt = tick ? 10'h000 : 10'(tickCnt + 10'h001);
	assign encoderTick = tick && clkEn;

	// Drive level picks the count set
	always_comb
	begin
		if (ctrl[`CTRL_LEVEL])
		begin
			selCnt.high = cfgHigh[`HC_MSB:`HC_LSB];
			selCnt.low  = cfgHigh[`LC_MSB:`LC_LSB];
		end
		else
		begin
			selCnt.high = cfgLow[`HC_MSB:`HC_LSB];
			selCnt.low  = cfgLow[`LC_MSB:`LC_LSB];
		end
	end

	assign selWave = (selCnt.high != 7'h00) && (selCnt.low != 7'h00);

	// Phase sequencer
	always_comb
	begin
		next_phase    = phase;
		next_phaseCnt = phaseCnt;
		next_act      = act;
		if (!ctrl[`CTRL_DIR])
		begin
			next_phase    = PH_STATIC;
			next_phaseCnt = 7'h00;
			next_act      = selCnt;
		end
		else
		begin
			unique case (phase)
				PH_STATIC:
				begin
					next_act = selCnt;
					if (tick && selWave)
					begin
						next_phase    = PH_HIGH;
						next_phaseCnt = 7'h00;
					end
				end
				PH_HIGH:
				begin
					if (tick && phaseCnt == 7'(act.high - 7'h01))
					begin
						next_phase    = PH_LOW;
						next_phaseCnt = 7'h00;
					end
					else if (tick)
						next_phaseCnt = 7'(phaseCnt + 7'h01);
				end
				PH_LOW:
				begin
					if (tick && phaseCnt == 7'(act.low - 7'h01))
					begin
						next_act      = selCnt;
						next_phaseCnt = 7'h00;
						next_phase    = selWave ? PH_HIGH : PH_STATIC;
					end
					else if (tick)
						next_phaseCnt = 7'(phaseCnt + 7'h01);
				end
				default: next_phase = PH_STATIC;
			endcase
		end
	end

	// Pin level from the coming phase
	always_comb
	begin
		next_pinOe = ctrl[`CTRL_DIR];
		if (!ctrl[`CTRL_DIR])
			next_pinOut = 1'b0;
		else if (next_phase == PH_HIGH)
			next_pinOut = 1'b1;
		else if (next_phase == PH_LOW)
			next_pinOut = 1'b0;
		else
			next_pinOut = (next_act.high != 7'h00) &&
				(next_act.low == 7'h00);
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			tickCnt  <= 10'h000;
			phase    <= PH_STATIC;
			phaseCnt <= 7'h00;
			act      <= '0;
			pinOut   <= 1'b0;
			pinOe    <= 1'b0;
		end
		else if (clkEn)
		begin
			tickCnt  <= next_tickCnt;
			phase    <= next_phase;
			phaseCnt <= next_phaseCnt;
			act      <= next_act;
			pinOut   <= next_pinOut;
			pinOe    <= next_pinOe;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	// A shorter base picked mid-count gives one early tick, left out
	a_tick_select: assert property (
		clkEn && encoderTick && $stable(cfgLow[`TB_MSB:`TB_LSB]) &&
			cfgLow[`TB_MSB:`TB_LSB] == 2'b00 |->
			tickCnt == `TB_DIV16_M1)
	else $error("tick not at divide by 16");

	a_tick_single: assert property (
		encoderTick ##1 clkEn |-> !encoderTick)
	else $error("tick longer than one cycle");

	a_input_idle: assert property (
		clkEn && !ctrl[0] |=> !pinOe && !pinOut &&
			phase == PH_STATIC)
	else $error("generator active while pin is input");

	a_enc_phase: assert property (
		clkEn && ctrl[`CTRL_DIR] && phase == PH_HIGH && !encoderTick |=>
			$stable(phaseCnt))
	else $error("phase count moved without tick");

	a_high_level: assert property (
		phase == PH_HIGH |-> pinOut && phaseCnt < act.high)
	else $error("high phase not driving high");

	a_low_level: assert property (
		phase == PH_LOW |-> !pinOut && phaseCnt < act.low)
	else $error("low phase not driving low");

	// Static level follows the selected counts at once, not the latched
	a_static_low: assert property (
		clkEn && ctrl[0] && phase == PH_STATIC &&
			selCnt.high == 7'h00 |=> !pinOut)
	else $error("zero high count not static low");

	a_static_high: assert property (
		clkEn && ctrl[0] && phase == PH_STATIC && !tick &&
			selCnt.high != 7'h00 && selCnt.low == 7'h00 |=> pinOut)
	else $error("zero low count not static high");

	a_both_zero: assert property (
		clkEn && ctrl[0] && phase == PH_STATIC &&
			selCnt == '0 |=> !pinOut)
	else $error("both counts zero not static low");

	a_reset_cfg: assert property (
		$fell(reset) |-> cfgLow == `LL_CFG_RST && !pinOut)
	else $error("low-level config reset value wrong");

	a_period_wrap: assert property (
		clkEn && phase == PH_LOW && tick &&
			phaseCnt == 7'(act.low - 7'h01) |=>
			phase != PH_LOW && phaseCnt == 7'h00)
	else $error("period did not restart at boundary");

	a_high_to_low: assert property (
		clkEn && ctrl[`CTRL_DIR] && phase == PH_HIGH && tick &&
			phaseCnt == 7'(act.high - 7'h01) |=> phase == PH_LOW)
	else $error("high phase did not end on count");
endmodule : gpio_low_level_pwm

// ### gpio_pwm_defines.svh
/*
 Register indices, field positions, reset values and tick dividers
 for the pin one PWM generator. Included by the design module.
*/
`ifndef GPIO_PWM_DEFINES_SVH
`define GPIO_PWM_DEFINES_SVH
`define LL_CFG_IDX   8'h51
`define LH_CFG_IDX   8'h52
`define CTRL_IDX     8'h60
`define LL_CFG_RST   16'h007F
`define LH_CFG_RST   16'h3F80
`define CTRL_RST     2'h0
`define TB_MSB       15
`define TB_LSB       14
`define HC_MSB       13
`define HC_LSB       7
`define LC_MSB       6
`define LC_LSB       0
`define CTRL_DIR     0
`define CTRL_LEVEL   1
`define TB_DIV16_M1  10'h00F
`define TB_DIV64_M1  10'h03F
`define TB_DIV256_M1 10'h0FF
`define TB_DIV1K_M1  10'h3FF
`endif

// ### gpio_pwm_pkg.sv
/*
 Types for the pin one PWM generator.
 Assumes nothing of its surroundings.
*/
package gpio_pwm_pkg;
	typedef enum logic [1:0] {
		PH_STATIC = 2'b00,
		PH_HIGH   = 2'b01,
		PH_LOW    = 2'b10
	} phase_e;

	typedef struct packed {
		logic [6:0] high;
		logic [6:0] low;
	} count_s;
endpackage : gpio_pwm_pkg

// ### gpio_low_level_pwm_bench.sv
/*
 Self-checking bench for the pin one PWM generator.
 Assumes the generator's register map and a single AHB-Lite slave.
*/
`timescale 1ns/1ps
`include "gpio_pwm_defines.svh"
module gpio_low_level_pwm_bench;
	localparam logic [31:0] LL = {22'h0, `LL_CFG_IDX, 2'h0};
	localparam logic [31:0] LH = {22'h0, `LH_CFG_IDX, 2'h0};
	localparam logic [31:0] CT = {22'h0, `CTRL_IDX, 2'h0};
	logic        core_clk = 1'b0;
	logic        reset = 1'b1;
	logic        clkEn = 1'b1;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic        hresp;
	logic        pinOut;
	logic        pinOe;
	logic        encoderTick;
	logic [31:0] rd;
	int          fails = 0;
	int          compares = 0;

	gpio_low_level_pwm i_dut (.core_clk(core_clk), .reset(reset),
		.clkEn(clkEn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .pinOut(pinOut), .pinOe(pinOe),
		.encoderTick(encoderTick));

	always #12.5 core_clk = ~core_clk;

	task automatic tally_and_finish;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// One single word transfer, held until hready is seen high
	task automatic bus(input logic w, input logic [31:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(rd, exp);
		check({31'h0, hresp}, 32'h0);
	endtask : rdchk

	task automatic tick_gap(input logic [1:0] tb, input int exp);
		int n;
		bus(1'b1, LL, {16'h0, tb, 14'h007F});
		repeat (2)
		begin
			n = 0;
			do
			begin
				@(posedge core_clk);
				n++;
			end
			while (encoderTick !== 1'b1);
		end
		check(n, exp);
	endtask : tick_gap

	// Lengths in clocks of one whole high and low phase
	task automatic pwm(input int eh, input int el);
		int h;
		int l;
		h = 0;
		l = 0;
		do @(posedge core_clk); while (pinOut !== 1'b0);
		do @(posedge core_clk); while (pinOut !== 1'b1);
		do
		begin
			@(posedge core_clk);
			h++;
		end
		while (pinOut === 1'b1);
		do
		begin
			@(posedge core_clk);
			l++;
		end
		while (pinOut === 1'b0);
		check(h, eh);
		check(l, el);
	endtask : pwm

	task automatic flat(input logic [31:0] cfg, input logic v);
		logic bad;
		bad = 1'b0;
		bus(1'b1, LL, cfg);
		repeat (250) @(posedge core_clk);
		repeat (200)
		begin
			@(posedge core_clk);
			bad = bad | (pinOut !== v);
		end
		check({31'h0, bad}, 32'h0);
	endtask : flat

	// Clock enable low must hold pinOut still, with hreadyout and encoderTick low
	task automatic freeze;
		logic p;
		logic bad;
		bad = 1'b0;
		clkEn <= 1'b0;
		@(posedge core_clk);
		p = pinOut;
		repeat (40)
		begin
			@(posedge core_clk);
			bad = bad | (pinOut !== p) | (hreadyout !== 1'b0) |
				(encoderTick !== 1'b0);
		end
		clkEn <= 1'b1;
		check({31'h0, bad}, 32'h0);
		check({31'h0, p}, 32'h1);
	endtask : freeze

	initial
	begin
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		rdchk(LL, 32'h007F);
		rdchk(LH, 32'h3F80);
		rdchk(32'h0000_0200, 32'h0);
		check({31'h0, pinOut}, 32'h0);
		bus(1'b1, CT, 32'h1);
		repeat (2) @(posedge core_clk);
		check({31'h0, pinOe}, 32'h1);
		bus(1'b1, LL, 32'h0101);
		pwm(32, 16);
		freeze;
		pwm(32, 16);
		for (int i = 0; i < 4; i++)
			tick_gap(i[1:0], 16 << (2 * i));
		bus(1'b1, LL, 32'h4101);
		pwm(128, 64);
		flat(32'h0005, 1'b0);
		flat(32'h0180, 1'b1);
		rdchk(CT, 32'h0000_0101);
		flat(32'h0000, 1'b0);
		bus(1'b1, LH, 32'hFFFF);
		rdchk(LH, 32'h3FFF);
		bus(1'b1, LH, 32'h0083);
		bus(1'b1, CT, 32'h3);
		pwm(16, 48);
		bus(1'b1, CT, 32'h0);
		repeat (3) @(posedge core_clk);
		check({31'h0, pinOe}, 32'h0);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		rdchk(LL, 32'h007F);
		rdchk(CT, 32'h0);
		tally_and_finish;
	end

	initial
	begin
		repeat (30000) @(posedge core_clk);
		fails++;
		tally_and_finish;
	end
endmodule : gpio_low_level_pwm_bench
